// File: pfm_fb_model.sv
/*
  frame buffer model: offers one pixel port word at a time with valid.
  assumes one caller of send at a time, synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
module pfm_fb_model #(
  parameter int WW = 160,
  parameter int OW = 10,
  parameter int CW = 5
) (
  input wire logic clk_sys_i,
  input wire logic pix_ready_i,
  output logic [WW-1:0] pix_word_o,
  output logic [OW-1:0] ovl_o,
  output logic [CW-1:0] choose_o,
  output logic pix_valid_o
);
  initial begin
    pix_word_o = '0;
    ovl_o = '0;
    choose_o = '0;
    pix_valid_o = 1'b0;
  end
  // gap gives a slow source; released lines invert so stale data never matches
  task automatic send(input logic [WW-1:0] w, input logic [OW-1:0] o,
                      input logic [CW-1:0] c, input int gap);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    pix_word_o <= w;
    ovl_o <= o;
    choose_o <= c;
    pix_valid_o <= 1'b1;
    do @(posedge clk_sys_i); while (pix_ready_i !== 1'b1);
    pix_word_o <= ~w;
    ovl_o <= ~o;
    choose_o <= ~c;
    pix_valid_o <= 1'b0;
  endtask
endmodule

// File: pfm_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock; width and depth are parameters, depth a power of two.
*/
`timescale 1ns/1ns
module pfm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_r != rp_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rp_r[AW-1:0]];

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// File: pfm_pixel_decode.sv
/*
  combinational decode of one pixel slot into table addresses and overlay code.
  assumes the slot is already aligned and zero above the pixel size.
*/
`timescale 1ns/1ns
module pfm_pixel_decode (
  input wire logic [31:0] slot_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] src_i,
  input wire logic [7:0] mask_i,
  input wire logic [1:0] ovl_mask_i,
  input wire logic [1:0] ovl_in_i,
  input wire logic choose_pin_i,
  input wire logic choose_by_value_i,
  output logic [7:0] pseudo_addr_o,
  output logic [7:0] red_o,
  output logic [7:0] green_o,
  output logic [7:0] blue_o,
  output logic use_pseudo_o,
  output logic [1:0] ovl_code_o
);
  logic [7:0] src_byte;

  always_comb begin
    case (src_i)
      pfm_pkg::SRC_BLUE: src_byte = slot_i[pfm_pkg::B32_LSB +: 8];
      pfm_pkg::SRC_GREEN: src_byte = slot_i[pfm_pkg::G32_LSB +: 8];
      pfm_pkg::SRC_RED: src_byte = slot_i[pfm_pkg::R32_LSB +: 8];
      default: src_byte = slot_i[pfm_pkg::P32_LSB +: 8];
    endcase
    pseudo_addr_o = src_byte & mask_i;
    ovl_code_o = ovl_in_i & ovl_mask_i;
    case (size_i)
      pfm_pkg::SIZE_8: begin
        use_pseudo_o = 1'b1;
        red_o = 8'h00;
        green_o = 8'h00;
        blue_o = 8'h00;
      end
      pfm_pkg::SIZE_16: begin
        // low bits of each component zero-filled
        use_pseudo_o = 1'b0;
        blue_o = {slot_i[pfm_pkg::B16_LSB +: 4], 4'h0};
        green_o = {slot_i[pfm_pkg::G16_LSB +: 6], 2'h0};
        red_o = {slot_i[pfm_pkg::R16_LSB +: 6], 2'h0};
      end
      default: begin
        // reserved size code decodes as 32-bit
        use_pseudo_o = choose_by_value_i ? (src_byte != 8'h00) : choose_pin_i;
        blue_o = slot_i[pfm_pkg::B32_LSB +: 8];
        green_o = slot_i[pfm_pkg::G32_LSB +: 8];
        red_o = slot_i[pfm_pkg::R32_LSB +: 8];
      end
    endcase
  end
endmodule

// File: pfm_pixel_format.sv
/*
  pixel format, mask and converter control: indirect register port,
  16-word pixel fifo, per-pixel serializer and decode, converter controls.
  assumes all inputs synchronous to clk_sys_i; the frame buffer honours ready.
*/
`timescale 1ns/1ns
module pfm_pixel_format #(
  parameter int PORTS = pfm_pkg::PORTS,
  parameter int MAX_PIX = pfm_pkg::MAX_PIX,
  parameter int DEPTH = pfm_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [1:0] rs_i,
  input wire logic [7:0] d_i,
  output logic [7:0] d_o,
  output logic d_oe_n_o,
  input wire logic [PORTS*8-1:0] pix_word_i,
  input wire logic [2*MAX_PIX-1:0] ovl_i,
  input wire logic [MAX_PIX-1:0] pseudo_choose_i,
  input wire logic choose_by_value_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [7:0] pseudo_addr_o,
  output logic [7:0] red_o,
  output logic [7:0] green_o,
  output logic [7:0] blue_o,
  output logic use_pseudo_o,
  output logic [1:0] ovl_code_o,
  output logic sync_pedestal_on_o,
  output logic blank_pedestal_on_o,
  output logic six_bit_o,
  output logic [1:0] contrast_o
);
  localparam int WW = PORTS * 8;
  localparam int EW = WW + 3 * MAX_PIX;
  localparam int IW = $clog2(MAX_PIX + 1);

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt;
  logic [7:0] set_r, set_nxt, index_r, index_nxt, mask_r, mask_nxt, rdata_r, rdata_nxt;
  logic [1:0] ovl_mask_r, ovl_mask_nxt;
  logic [6:0] mode_r, mode_nxt;
  logic [4:0] dac_r, dac_nxt;
  logic wr_fall, rd_fall;

  assign wr_fall = wr_n_r && !wr_n_i;
  assign rd_fall = rd_n_r && !rd_n_i;

  always_comb begin
    wr_n_nxt = wr_n_i;
    rd_n_nxt = rd_n_i;
    set_nxt = set_r;
    index_nxt = index_r;
    mask_nxt = mask_r;
    ovl_mask_nxt = ovl_mask_r;
    mode_nxt = mode_r;
    dac_nxt = dac_r;
    rdata_nxt = rdata_r;
    if (wr_fall) begin
      case (rs_i)
        pfm_pkg::RS_SET: set_nxt = d_i;
        pfm_pkg::RS_INDEX: index_nxt = d_i;
        pfm_pkg::RS_DATA: begin
          // index is not consulted for these sets
          case (set_r)
            pfm_pkg::SET_PSEUDO_MASK: mask_nxt = d_i;
            pfm_pkg::SET_OVL_MASK: ovl_mask_nxt = d_i[1:0];
            pfm_pkg::SET_DAC: dac_nxt = d_i[4:0];
            pfm_pkg::SET_PIX_MODE: mode_nxt = d_i[6:0];
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    if (rd_fall) begin
      rdata_nxt = 8'h00;
      case (rs_i)
        pfm_pkg::RS_SET: rdata_nxt = set_r;
        pfm_pkg::RS_INDEX: rdata_nxt = index_r;
        pfm_pkg::RS_DATA: begin
          case (set_r)
            pfm_pkg::SET_PSEUDO_MASK: rdata_nxt = mask_r;
            pfm_pkg::SET_OVL_MASK: rdata_nxt = {6'h00, ovl_mask_r};
            pfm_pkg::SET_DAC: rdata_nxt = {3'h0, dac_r};
            pfm_pkg::SET_PIX_MODE: rdata_nxt = {1'h0, mode_r};
            default: rdata_nxt = 8'h00;
          endcase
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      set_r <= pfm_pkg::RST_SET;
      index_r <= pfm_pkg::RST_INDEX;
      mask_r <= pfm_pkg::RST_PSEUDO_MASK;
      ovl_mask_r <= pfm_pkg::RST_OVL_MASK;
      mode_r <= pfm_pkg::RST_PIX_MODE;
      dac_r <= pfm_pkg::RST_DAC;
      rdata_r <= 8'h00;
    end else begin
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
      set_r <= set_nxt;
      index_r <= index_nxt;
      mask_r <= mask_nxt;
      ovl_mask_r <= ovl_mask_nxt;
      mode_r <= mode_nxt;
      dac_r <= dac_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // bus driven only while read enable is low
  assign d_o = rdata_r;
  assign d_oe_n_o = rd_n_i;

  assign sync_pedestal_on_o = !dac_r[pfm_pkg::DAC_SYNC_BIT];
  assign blank_pedestal_on_o = !dac_r[pfm_pkg::DAC_BLANK_BIT];
  assign six_bit_o = dac_r[pfm_pkg::DAC_RES_BIT];
  assign contrast_o = dac_r[pfm_pkg::DAC_CON_LSB +: 2];

  // ----------------------------------------
  // pixel fifo
  // ----------------------------------------
  logic [EW-1:0] fifo_data;
  logic fifo_valid, fifo_pop;

  pfm_fifo #(.W(EW), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_data_i({pseudo_choose_i, ovl_i, pix_word_i}),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // ----------------------------------------
  // serializer: one pixel per clock, so the pixel rate is
  // acceleration times the word rate
  // ----------------------------------------
  typedef enum logic [1:0] {
    PFM_IDLE = 2'b01,
    PFM_EMIT = 2'b10
  } pfm_state_e;

  pfm_state_e state_r, state_nxt;
  logic [EW-1:0] word_r, word_nxt;
  logic [IW-1:0] idx_r, idx_nxt, last_r, last_nxt, acc_cnt;
  logic [1:0] size_r, size_nxt;
  logic adv, last_pix;
  logic [2:0] acc_f;

  assign acc_f = mode_r[pfm_pkg::ACC_LSB +: 3];
  // factor zero taken as one; factors beyond MAX_PIX slots are capped at MAX_PIX
  assign acc_cnt = (acc_f == 3'h0) ? IW'(1) :
                   ((32'(acc_f) > MAX_PIX) ? IW'(MAX_PIX) : IW'(acc_f));
  assign adv = (state_r == PFM_EMIT) && (!out_valid_o || out_ready_i);
  assign last_pix = (idx_r == last_r);
  assign fifo_pop = fifo_valid && ((state_r == PFM_IDLE) || (adv && last_pix));

  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    size_nxt = size_r;
    case (state_r)
      PFM_IDLE: begin
        if (fifo_valid) begin
          state_nxt = PFM_EMIT;
        end
      end
      PFM_EMIT: begin
        if (adv) begin
          idx_nxt = idx_r + IW'(1);
          if (last_pix && !fifo_valid) begin
            state_nxt = PFM_IDLE;
          end
        end
      end
      default: state_nxt = PFM_IDLE;
    endcase
    if (fifo_pop) begin
      word_nxt = fifo_data;
      idx_nxt = '0;
      last_nxt = acc_cnt - IW'(1);
      size_nxt = mode_r[pfm_pkg::SIZE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= PFM_IDLE;
      word_r <= '0;
      idx_r <= '0;
      last_r <= '0;
      size_r <= pfm_pkg::SIZE_32;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      size_r <= size_nxt;
    end
  end

  // ----------------------------------------
  // slot extraction and decode
  // ----------------------------------------
  logic [31:0] slot;
  logic [WW-1:0] shifted;
  logic [7:0] bits_pp;
  logic [7:0] d_pa, d_r, d_g, d_b;
  logic d_up;
  logic [1:0] d_ovl;

  always_comb begin
    case (size_r)
      pfm_pkg::SIZE_8: bits_pp = 8'h08;
      pfm_pkg::SIZE_16: bits_pp = 8'h10;
      default: bits_pp = 8'h20;
    endcase
    shifted = word_r[WW-1:0] >> (8'(idx_r) * bits_pp);
    case (size_r)
      pfm_pkg::SIZE_8: slot = {24'h000000, shifted[7:0]};
      pfm_pkg::SIZE_16: slot = {16'h0000, shifted[15:0]};
      default: slot = shifted[31:0];
    endcase
  end

  pfm_pixel_decode u_dec (
    .slot_i(slot),
    .size_i(size_r),
    .src_i(mode_r[pfm_pkg::SRC_LSB +: 2]),
    .mask_i(mask_r),
    .ovl_mask_i(ovl_mask_r),
    .ovl_in_i(word_r[WW + 2*idx_r +: 2]),
    .choose_pin_i(word_r[WW + 2*MAX_PIX + idx_r]),
    .choose_by_value_i(choose_by_value_i),
    .pseudo_addr_o(d_pa),
    .red_o(d_r),
    .green_o(d_g),
    .blue_o(d_b),
    .use_pseudo_o(d_up),
    .ovl_code_o(d_ovl)
  );

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  logic ov_r, ov_nxt;
  logic [34:0] o_r, o_nxt;

  always_comb begin
    ov_nxt = ov_r;
    o_nxt = o_r;
    if (adv) begin
      ov_nxt = 1'b1;
      o_nxt = {d_ovl, d_up, d_b, d_g, d_r, d_pa};
    end else if (out_ready_i) begin
      ov_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_r <= 1'b0;
      o_r <= '0;
    end else begin
      ov_r <= ov_nxt;
      o_r <= o_nxt;
    end
  end

  assign out_valid_o = ov_r;
  assign {ovl_code_o, use_pseudo_o, blue_o, green_o, red_o, pseudo_addr_o} = o_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence data_wr_s(logic [7:0] s);
    wr_fall && rs_i == pfm_pkg::RS_DATA && set_r == s;
  endsequence

  mask_and_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(adv) |-> (pseudo_addr_o & ~$past(mask_r)) == 8'h00)
    else $error("pseudo address outside mask");
  zero_mask_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(adv) && $past(mask_r) == 8'h00 |-> pseudo_addr_o == 8'h00)
    else $error("zero mask did not clear address");
  ovl_gate_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(adv) |-> (ovl_code_o & ~$past(ovl_mask_r)) == 2'h0)
    else $error("disabled overlay plane seen");
  size8_pseudo_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(adv) && $past(size_r) == pfm_pkg::SIZE_8 |-> use_pseudo_o)
    else $error("8-bit pixel not pseudo");
  size16_fill_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(adv) && $past(size_r) == pfm_pkg::SIZE_16
      |-> !use_pseudo_o && blue_o[3:0] == 4'h0 && green_o[1:0] == 2'h0)
    else $error("16-bit pixel decode wrong");
  dac_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    data_wr_s(pfm_pkg::SET_DAC) |=> sync_pedestal_on_o == !$past(d_i[0])
      && six_bit_o == $past(d_i[2]) && contrast_o == $past(d_i[4:3]))
    else $error("converter control not applied");
  ovl_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    rd_fall && rs_i == pfm_pkg::RS_DATA && set_r == pfm_pkg::SET_OVL_MASK
      |=> rdata_r[7:2] == 6'h00)
    else $error("reserved bits read nonzero");
  mask_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    data_wr_s(pfm_pkg::SET_PSEUDO_MASK) |=> mask_r == $past(d_i))
    else $error("mask write lost");
endmodule

// File: pfm_pixel_format_tb_top.sv
/*
  self-checking bench: register port tasks, frame buffer model, pixel scoreboard.
  assumes default top parameters: 20 lanes, 5 slots, 16-word fifo.
*/
`timescale 1ns/1ns
module pfm_pixel_format_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic u;
    logic [1:0] o;
    logic [5:0] m;
  } pfm_exp_s;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wr_n_i = 1'b1;
  logic rd_n_i = 1'b1;
  logic [1:0] rs_i = 2'h0;
  logic [7:0] d_i = 8'h00;
  logic choose_by_value_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic [7:0] d_o, pseudo_addr_o, red_o, green_o, blue_o;
  logic d_oe_n_o, pix_valid_i, pix_ready_o, out_valid_o, use_pseudo_o;
  logic sync_pedestal_on_o, blank_pedestal_on_o, six_bit_o;
  logic [1:0] ovl_code_o, contrast_o;
  logic [159:0] pix_word_i;
  logic [9:0] ovl_i;
  logic [4:0] pseudo_choose_i;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  integer seed = 32'h5c1166e0;
  logic stall = 1'b0;
  logic [6:0] mode = 7'h05;
  logic [7:0] mask = 8'hFF;
  logic [1:0] ovlm = 2'h0;
  pfm_exp_s expq[$];
  pfm_exp_s mon_e;
  logic [6:0] md_t[7] = '{7'h15, 7'h01, 7'h16, 7'h10, 7'h34, 7'h5C, 7'h68};
  logic [7:0] mk_t[7] = '{8'hA5, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h3C, 8'hF0};
  logic [1:0] om_t[7] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 2'h3, 2'h1};
  logic [7:0] dv_t[8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1F, 8'hFF};

  pfm_pixel_format pfm_pixel_format_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .rs_i(rs_i), .d_i(d_i), .d_o(d_o),
    .d_oe_n_o(d_oe_n_o), .pix_word_i(pix_word_i), .ovl_i(ovl_i),
    .pseudo_choose_i(pseudo_choose_i), .choose_by_value_i(choose_by_value_i),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .pseudo_addr_o(pseudo_addr_o), .red_o(red_o),
    .green_o(green_o), .blue_o(blue_o), .use_pseudo_o(use_pseudo_o),
    .ovl_code_o(ovl_code_o), .sync_pedestal_on_o(sync_pedestal_on_o),
    .blank_pedestal_on_o(blank_pedestal_on_o), .six_bit_o(six_bit_o),
    .contrast_o(contrast_o));
  pfm_fb_model pfm_fb_model_inst (.clk_sys_i(clk_sys_i), .pix_ready_i(pix_ready_o),
    .pix_word_o(pix_word_i), .ovl_o(ovl_i), .choose_o(pseudo_choose_i),
    .pix_valid_o(pix_valid_i));

  always #20 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
  // ----------------------------------------
  // register port
  // ----------------------------------------
  task automatic wr(input logic [1:0] r, input logic [7:0] v);
    @(posedge clk_sys_i);
    wr_n_i <= 1'b0;
    rs_i <= r;
    d_i <= v;
    @(posedge clk_sys_i);
    wr_n_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [1:0] r, input logic [7:0] v);
    @(posedge clk_sys_i);
    rd_n_i <= 1'b0;
    rs_i <= r;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("d_oe_n_o", d_oe_n_o, 0);
    chk("d_o", d_o, v);
    @(posedge clk_sys_i);
    rd_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("d_oe_n_o idle", d_oe_n_o, 1);
  endtask
  // random index before each data access: single-location sets must ignore it
  task automatic setreg(input logic [7:0] s, input logic [7:0] v);
    wr(pfm_pkg::RS_SET, s);
    wr(pfm_pkg::RS_INDEX, 8'($random(seed)));
    wr(pfm_pkg::RS_DATA, v);
  endtask
  // ----------------------------------------
  // pixel expectation and traffic
  // ----------------------------------------
  function automatic pfm_exp_s expv(input logic [159:0] w, input int k,
                                    input logic [1:0] o, input logic c);
    pfm_exp_s e;
    logic [31:0] s;
    logic [7:0] p;
    e = '0;
    e.o = o & ovlm;
    case (mode[1:0])
      pfm_pkg::SIZE_8: begin
        e.a = w[8*k +: 8] & mask;
        e.u = 1'b1;
        e.m = 6'h23;
      end
      pfm_pkg::SIZE_16: begin
        s = {16'h0000, w[16*k +: 16]};
        e.b = {s[3:0], 4'h0};
        e.g = {s[9:4], 2'h0};
        e.r = {s[15:10], 2'h0};
        e.m = 6'h1F;
      end
      default: begin
        s = w[32*k +: 32];
        p = s[8*mode[6:5] +: 8];
        e.a = p & mask;
        e.r = s[31:24];
        e.g = s[23:16];
        e.b = s[15:8];
        e.u = choose_by_value_i ? (p != 8'h00) : c;
        e.m = 6'h3F;
      end
    endcase
    return e;
  endfunction
  task automatic burst(input int cnt, input int gap);
    logic [159:0] w;
    logic [9:0] o;
    logic [4:0] c;
    int np;
    np = (mode[4:2] == 3'h0) ? 1 : ((mode[4:2] > 3'h5) ? 5 : int'(mode[4:2]));
    for (int i = 0; i < cnt; i++) begin
      w = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      o = 10'($random(seed));
      c = 5'($random(seed));
      for (int k = 0; k < np; k++) expq.push_back(expv(w, k, o[2*k +: 2], c[k]));
      pfm_fb_model_inst.send(w, o, c, gap);
    end
  endtask
  task automatic drain();
    for (int t = 0; t < 3000 && expq.size() != 0; t++) @(posedge clk_sys_i);
    repeat (8) @(posedge clk_sys_i);
    chk("pixels left", expq.size(), 0);
  endtask
  always @(posedge clk_sys_i) out_ready_i <= !stall && (($random(seed) & 3) != 0);
  always @(posedge clk_sys_i) begin
    if (resetn_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      if (expq.size() == 0) chk("extra pixel", 1, 0);
      else begin
        mon_e = expq.pop_front();
        if (mon_e.m[5]) chk("pseudo_addr_o", pseudo_addr_o, mon_e.a);
        if (mon_e.m[4]) chk("red_o", red_o, mon_e.r);
        if (mon_e.m[3]) chk("green_o", green_o, mon_e.g);
        if (mon_e.m[2]) chk("blue_o", blue_o, mon_e.b);
        chk("use_pseudo_o", use_pseudo_o, mon_e.u);
        chk("ovl_code_o", ovl_code_o, mon_e.o);
      end
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("sync ped rst", sync_pedestal_on_o, 1);
    chk("six_bit rst", six_bit_o, 0);
    chk("contrast rst", contrast_o, 0);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wr(pfm_pkg::RS_SET, 8'h41);
    wr(pfm_pkg::RS_DATA, 8'h12);
    wr(pfm_pkg::RS_SET, pfm_pkg::SET_PSEUDO_MASK);
    rd(pfm_pkg::RS_DATA, pfm_pkg::RST_PSEUDO_MASK);
    rd(2'h3, 8'h00);
    setreg(pfm_pkg::SET_PIX_MODE, 8'hFF);
    rd(pfm_pkg::RS_DATA, 8'h7F);
    setreg(pfm_pkg::SET_OVL_MASK, 8'hFF);
    rd(pfm_pkg::RS_DATA, 8'h03);
    foreach (dv_t[i]) begin
      setreg(pfm_pkg::SET_DAC, dv_t[i]);
      #1;
      chk("sync_pedestal_on_o", sync_pedestal_on_o, !dv_t[i][0]);
      chk("blank_pedestal_on_o", blank_pedestal_on_o, !dv_t[i][1]);
      chk("six_bit_o", six_bit_o, dv_t[i][2]);
      chk("contrast_o", contrast_o, dv_t[i][4:3]);
      rd(pfm_pkg::RS_DATA, dv_t[i] & 8'h1F);
    end
    // traffic only with legal size codes
    foreach (md_t[i]) begin
      mode = md_t[i];
      mask = mk_t[i];
      ovlm = om_t[i];
      choose_by_value_i <= (i == 4);
      setreg(pfm_pkg::SET_PIX_MODE, {1'b0, mode});
      setreg(pfm_pkg::SET_PSEUDO_MASK, mask);
      setreg(pfm_pkg::SET_OVL_MASK, {6'h00, ovlm});
      burst(5, (i % 2) * 3);
      drain();
    end
    stall = 1'b1;
    n = 0;
    while (pix_ready_o === 1'b1 && n < 24) begin
      burst(1, 0);
      n++;
      #1;
    end
    chk("pix_ready_o full", pix_ready_o, 0);
    chk("words held", n >= 16, 1);
    stall = 1'b0;
    drain();
    summarize();
  end
endmodule

// File: pfm_pkg.sv
/*
  shared constants of the pixel format, mask and converter control block.
  assumes one system clock and the 8-bit indirect set/index/data port.
*/
package pfm_pkg;
  // ----------------------------------------
  // pixel port geometry
  // ----------------------------------------
  localparam int PORTS = 20;
  localparam int BYTE_W = 8;
  localparam int MAX_PIX = 5;
  localparam int WORD_W = PORTS * BYTE_W;
  localparam int FIFO_DEPTH = 16;
  localparam int OVL_W = 2;
  localparam int MODE_W = 7;
  localparam int DAC_W = 5;
  // ----------------------------------------
  // register select and set codes
  // ----------------------------------------
  localparam logic [1:0] RS_SET = 2'h0;
  localparam logic [1:0] RS_INDEX = 2'h1;
  localparam logic [1:0] RS_DATA = 2'h2;
  localparam logic [7:0] SET_PSEUDO_MASK = 8'h40;
  localparam logic [7:0] SET_OVL_MASK = 8'h43;
  localparam logic [7:0] SET_DAC = 8'h46;
  localparam logic [7:0] SET_PIX_MODE = 8'h49;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SET = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_PSEUDO_MASK = 8'hFF;
  localparam logic [1:0] RST_OVL_MASK = 2'h0;
  localparam logic [6:0] RST_PIX_MODE = 7'h05;
  localparam logic [4:0] RST_DAC = 5'h00;
  // ----------------------------------------
  // pixel mode fields
  // ----------------------------------------
  localparam int SIZE_LSB = 0;
  localparam int ACC_LSB = 2;
  localparam int SRC_LSB = 5;
  localparam logic [1:0] SIZE_32 = 2'h0;
  localparam logic [1:0] SIZE_8 = 2'h1;
  localparam logic [1:0] SIZE_16 = 2'h2;
  localparam logic [1:0] SRC_PSEUDO = 2'h0;
  localparam logic [1:0] SRC_BLUE = 2'h1;
  localparam logic [1:0] SRC_GREEN = 2'h2;
  localparam logic [1:0] SRC_RED = 2'h3;
  // ----------------------------------------
  // pixel word layouts
  // ----------------------------------------
  localparam int B16_LSB = 0;
  localparam int G16_LSB = 4;
  localparam int R16_LSB = 10;
  localparam int P32_LSB = 0;
  localparam int B32_LSB = 8;
  localparam int G32_LSB = 16;
  localparam int R32_LSB = 24;
  // ----------------------------------------
  // converter control fields
  // ----------------------------------------
  localparam int DAC_SYNC_BIT = 0;
  localparam int DAC_BLANK_BIT = 1;
  localparam int DAC_RES_BIT = 2;
  localparam int DAC_CON_LSB = 3;
  localparam logic [1:0] CON_FULL = 2'h0;
  localparam logic [1:0] CON_HALF = 2'h1;
  localparam logic [1:0] CON_QUARTER = 2'h2;
  localparam logic [1:0] CON_BLANKED = 2'h3;
endpackage
